// ### cft_closure_trip.sv
// Closure fault trip stage with Avalon-MM register slave
`timescale 1ns/10ps
// Function
// [R1] Breaker is seen open while the largest phase current is below 0.02 x In.
// [R2] A selected digital or virtual input may instead indicate the open breaker.
// [R3] With select zero, the default, only the current comparison detects open.
// [R4] The stage arms only after open has lasted the whole dead-line delay.
// [R5] Overcurrent before the dead-line delay has elapsed gives no trip.
// [R6] Without a preceding open period an overcurrent never trips.
// [R7] After arming, leaving open marks closure and overcurrent in the window trips.
// [R8] Once the window has expired no trip is given.
// [R9] The trip is issued with no intentional delay.
// [R10] One single set of settings exists, no setting groups.
// [R11] Start setting is held between 1.00 and 3.00 x In in 0.01 steps.
// [R12] Dead-line delay is held between 0.00 and 60.00 s in 0.01 s steps.
// [R13] Closure window is held between 0.10 and 60.00 s in 0.01 s steps.
// [R14] Trip follows within 30 ms when current exceeds 1.5 times the setting.
// [R15] Trip holds while current stays above start, then a new open is needed.
// [R16] Timers count 10 ms ticks and the dead-line count restarts when open drops.
module cft_closure_trip #(
  parameter int unsigned TICK_CYCLES = cft_pkg::TICK_CYCLES_DEF,
  parameter int unsigned NUM_DIG     = cft_pkg::NUM_DIG_DEF
) (
  // Clock and reset
  input  wire logic                        MCLK_IN,
  input  wire logic                        RESET_N_IN,
  // Avalon-MM slave
  input  wire logic [cft_pkg::ADDR_W-1:0]  AVS_ADDRESS_IN,
  input  wire logic                        AVS_READ_IN,
  input  wire logic                        AVS_WRITE_IN,
  input  wire logic [31:0]                 AVS_WRITEDATA_IN,
  input  wire logic [3:0]                  AVS_BYTEENABLE_IN,
  output logic      [31:0]                 AVS_READDATA_OUT,
  output logic                             AVS_WAITREQUEST_OUT,
  // Phase current magnitudes
  input  wire logic [cft_pkg::CUR_W-1:0]   IL1_IN,
  input  wire logic [cft_pkg::CUR_W-1:0]   IL2_IN,
  input  wire logic [cft_pkg::CUR_W-1:0]   IL3_IN,
  // Breaker open pins
  input  wire logic [NUM_DIG-1:0]          DIGITAL_OPEN_INPUTS_IN,
  // Stage outputs
  output logic                             TRIP_OUT,
  output logic                             TRIP_EVENT_OUT,
  output logic                             ARMED_OUT,
  output logic                             IRQ_OUT
);
  import cft_pkg::*;

  localparam int unsigned TCW = $clog2(TICK_CYCLES + 1);
  localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES - 1);

  // Settings and software state
  logic                  enable_r;
  logic [SEL_W-1:0]      sel_r;
  logic [CUR_W-1:0]      start_r;
  logic [TMR_W-1:0]      dead_r;
  logic [TMR_W-1:0]      win_r;
  logic [NUM_VIRT-1:0]   virtual_open_inputs_r;
  logic [IRQ_W-1:0]      irq_stat_r;
  logic [IRQ_W-1:0]      irq_mask_r;
  // Bus handshake
  logic                  wreq_r;
  logic [31:0]           rdata_r;
  logic                  wr_take;
  logic                  rd_take;
  logic [31:0]           cur_word;
  logic [31:0]           wr_word;
  // Measurement and detection
  logic [NUM_DIG-1:0]    dig_s1_r;
  logic [NUM_DIG-1:0]    dig_s2_r;
  logic [CUR_W-1:0]      imax_r;
  logic [CUR_W-1:0]      imax_nxt;
  logic                  sel_level;
  logic                  sel_valid;
  logic                  open_cond;
  logic                  over_start;
  // Tick and state
  logic [TCW-1:0]        tick_cnt_r;
  logic                  tick_r;
  cft_state_t            state_r;
  cft_state_t            state_nxt;
  logic                  trip_r;
  logic                  trip_ev_r;
  logic                  armed_r;
  logic                  irq_r;
  logic [IRQ_W-1:0]      ev;

  cft_tmr_if dead_if ();
  cft_tmr_if win_if ();

  // Merge write data into a word under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Clamp a setting into its legal range
  function automatic logic [CUR_W-1:0] clamp(input logic [CUR_W-1:0] v, input logic [CUR_W-1:0] lo,
                                             input logic [CUR_W-1:0] hi);
    logic [CUR_W-1:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // One wait cycle, then the answer with waitrequest low
  assign wr_take = AVS_WRITE_IN && !wreq_r;
  assign rd_take = AVS_READ_IN && !wreq_r;

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      wreq_r <= 1'b1;
    end else begin
      wreq_r <= !((AVS_READ_IN || AVS_WRITE_IN) && wreq_r);
    end
  end

  // Current value of the addressed register
  always_comb begin
    unique case (AVS_ADDRESS_IN)
      OFS_CTRL:     cur_word = {19'h0_0000, sel_r, 7'h00, enable_r};
      OFS_START:    cur_word = {16'h0000, start_r};
      OFS_DEAD:     cur_word = {19'h0_0000, dead_r};
      OFS_WIN:      cur_word = {19'h0_0000, win_r};
      OFS_VIRT:     cur_word = {24'h00_0000, virtual_open_inputs_r};
      OFS_STATUS:   cur_word = {21'h00_0000, sel_level, open_cond, trip_r, 3'h0, state_r};
      OFS_IRQ_STAT: cur_word = {29'h0000_0000, irq_stat_r};
      OFS_IRQ_MASK: cur_word = {29'h0000_0000, irq_mask_r};
      OFS_IMAX:     cur_word = {16'h0000, imax_r};
      default:      cur_word = 32'h0000_0000;
    endcase
  end

  assign wr_word = be_merge(cur_word, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);

  // Read data captured as the waitrequest drops
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rdata_r <= 32'h0000_0000;
    end else if (AVS_READ_IN && wreq_r) begin
      rdata_r <= cur_word;
    end
  end

  // [R10] single settings set
  // [R11] start setting clamped
  // [R12] dead-line delay clamped
  // [R13] window clamped
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      enable_r              <= RST_ENABLE;
      sel_r                 <= RST_SEL;
      start_r               <= RST_START;
      dead_r                <= RST_DEAD;
      win_r                 <= RST_WIN;
      virtual_open_inputs_r <= '0;
      irq_mask_r            <= '0;
    end else if (wr_take) begin
      unique case (AVS_ADDRESS_IN)
        OFS_CTRL: begin
          enable_r <= wr_word[CTRL_EN_BIT];
          sel_r    <= wr_word[CTRL_SEL_LSB +: SEL_W];
        end
        OFS_START:    start_r <= clamp(wr_word[CUR_W-1:0], START_MIN, START_MAX);
        OFS_DEAD:     dead_r  <= TMR_W'(clamp({3'h0, wr_word[TMR_W-1:0]}, {3'h0, DEAD_MIN}, {3'h0, DEAD_MAX}));
        OFS_WIN:      win_r   <= TMR_W'(clamp({3'h0, wr_word[TMR_W-1:0]}, {3'h0, WIN_MIN}, {3'h0, WIN_MAX}));
        OFS_VIRT:     virtual_open_inputs_r <= wr_word[NUM_VIRT-1:0];
        OFS_IRQ_MASK: irq_mask_r <= wr_word[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Two-stage synchroniser for the breaker open pins
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      dig_s1_r <= '0;
      dig_s2_r <= '0;
    end else begin
      dig_s1_r <= DIGITAL_OPEN_INPUTS_IN;
      dig_s2_r <= dig_s1_r;
    end
  end

  // Largest of the three phase currents
  always_comb begin
    imax_nxt = IL1_IN;
    if (IL2_IN > imax_nxt) begin
      imax_nxt = IL2_IN;
    end
    if (IL3_IN > imax_nxt) begin
      imax_nxt = IL3_IN;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      imax_r <= '0;
    end else begin
      imax_r <= imax_nxt;
    end
  end

  // [R2] selected open input
  always_comb begin
    sel_level = 1'b0;
    sel_valid = 1'b0;
    for (int i = 0; i < NUM_DIG; i++) begin
      if (sel_r == SEL_W'(i + 1)) begin
        sel_level = dig_s2_r[i];
        sel_valid = 1'b1;
      end
    end
    for (int j = 0; j < NUM_VIRT; j++) begin
      if (sel_r == SEL_W'(NUM_DIG + j + 1)) begin
        sel_level = virtual_open_inputs_r[j];
        sel_valid = 1'b1;
      end
    end
  end

  // [R1] low limit detection
  // [R3] current only by default
  assign open_cond  = sel_valid ? sel_level : (imax_r < LOW_LIMIT);
  assign over_start = imax_r > start_r;

  // [R16] 10 ms tick prescaler
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_r     <= (tick_cnt_r == TICK_LAST);
      tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? '0 : tick_cnt_r + 1'b1;
    end
  end

  // [R16] dead-line count restarts when open drops
  assign dead_if.tick  = tick_r;
  assign dead_if.run   = enable_r && (state_r == ST_WAIT_OPEN) && open_cond;
  assign dead_if.limit = dead_r;
  assign win_if.tick   = tick_r;
  assign win_if.run    = enable_r && (state_r == ST_CLOSED);
  assign win_if.limit  = win_r;

  cft_timer u_dead_tmr (
    .MCLK_IN    (MCLK_IN),
    .RESET_N_IN (RESET_N_IN),
    .tmr_if     (dead_if.tmr)
  );

  cft_timer u_win_tmr (
    .MCLK_IN    (MCLK_IN),
    .RESET_N_IN (RESET_N_IN),
    .tmr_if     (win_if.tmr)
  );

  // Stage sequence
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      // [R4] arm after full delay
      // [R5] early overcurrent ignored
      // [R6] no open, no trip
      ST_WAIT_OPEN: if (open_cond && dead_if.done) begin
        state_nxt = ST_ARMED;
      end
      // [R7] leaving open marks closure
      ST_ARMED: if (!open_cond) begin
        state_nxt = over_start ? ST_TRIP : ST_CLOSED;
      end
      // [R8] expiry suppresses trip
      ST_CLOSED: begin
        if (win_if.done) begin
          state_nxt = ST_LOCK;
        end else if (over_start) begin
          state_nxt = ST_TRIP;
        end else if (open_cond) begin
          state_nxt = ST_WAIT_OPEN;
        end
      end
      // [R15] hold while above start
      ST_TRIP: if (!over_start) begin
        state_nxt = ST_LOCK;
      end
      // [R15] new open period needed
      ST_LOCK: if (open_cond) begin
        state_nxt = ST_WAIT_OPEN;
      end
      default: state_nxt = ST_WAIT_OPEN;
    endcase
    if (!enable_r) begin
      state_nxt = ST_WAIT_OPEN;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_r <= ST_WAIT_OPEN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // [R9] undelayed trip output
  // [R14] trip within a few cycles
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      trip_r    <= 1'b0;
      trip_ev_r <= 1'b0;
      armed_r   <= 1'b0;
    end else begin
      trip_r    <= (state_nxt == ST_TRIP);
      trip_ev_r <= (state_nxt == ST_TRIP) && (state_r != ST_TRIP);
      armed_r   <= (state_nxt == ST_ARMED) || (state_nxt == ST_CLOSED);
    end
  end

  // Events: trip entry, arming, window expiry
  assign ev[IRQ_TRIP_BIT] = (state_nxt == ST_TRIP) && (state_r != ST_TRIP);
  assign ev[IRQ_ARM_BIT]  = (state_nxt == ST_ARMED) && (state_r == ST_WAIT_OPEN);
  assign ev[IRQ_EXP_BIT]  = (state_r == ST_CLOSED) && (state_nxt == ST_LOCK);

  // Sticky status, write one to clear, new event wins
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      irq_stat_r <= '0;
    end else if (wr_take && (AVS_ADDRESS_IN == OFS_IRQ_STAT) && AVS_BYTEENABLE_IN[0]) begin
      irq_stat_r <= (irq_stat_r & ~AVS_WRITEDATA_IN[IRQ_W-1:0]) | ev;
    end else begin
      irq_stat_r <= irq_stat_r | ev;
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Outputs straight from flip-flops
  assign AVS_READDATA_OUT    = rdata_r;
  assign AVS_WAITREQUEST_OUT = wreq_r;
  assign TRIP_OUT            = trip_r;
  assign TRIP_EVENT_OUT      = trip_ev_r;
  assign ARMED_OUT           = armed_r;
  assign IRQ_OUT             = irq_r;

endmodule // cft_closure_trip

// ### cft_closure_trip_test.sv
// Self-checking testbench of the closure fault trip stage
`timescale 1ns/10ps
module cft_closure_trip_test;
  import cft_pkg::*;
  localparam int unsigned TICK = 10;
  typedef struct {int st; int dd; int wn; int op; int pr; int fl; logic ar; logic tr;} cft_row_t;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic [ADDR_W-1:0]      addr = '0;
  logic                   rd = 1'b0;
  logic                   wr = 1'b0;
  logic [31:0]            wdata = '0;
  logic [31:0]            rdata;
  logic                   wait_req;
  logic [CUR_W-1:0]       level = 16'h0032;
  logic [1:0]             phase = 2'h0;
  logic [CUR_W-1:0]       il1, il2, il3;
  logic [NUM_DIG_DEF-1:0] dig = '0;
  logic                   trip, trip_evt, armed, irq;
  logic [31:0]            q;
  int                     n_errors = 0;
  int                     num_checks = 0;
  int                     n_evt = 0;
  cft_row_t rows [5] = '{
    '{150, 2, 10, 5, 2, 151, 1'b1, 1'b1},
    '{150, 2, 10, 5, 2, 150, 1'b1, 1'b0},
    '{100, 5, 10, 2, 2, 400, 1'b0, 1'b0},
    '{100, 2, 10, 5, 15, 400, 1'b1, 1'b0},
    '{100, 0, 10, 1, 2, 400, 1'b1, 1'b1}};

  // Clock
  always #5 clk = ~clk;

  cft_closure_trip #(.TICK_CYCLES(TICK), .NUM_DIG(NUM_DIG_DEF)) cft_closure_trip_i (
    .MCLK_IN(clk), .RESET_N_IN(rst_n), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
    .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdata),
    .AVS_WAITREQUEST_OUT(wait_req), .IL1_IN(il1), .IL2_IN(il2), .IL3_IN(il3),
    .DIGITAL_OPEN_INPUTS_IN(dig), .TRIP_OUT(trip), .TRIP_EVENT_OUT(trip_evt), .ARMED_OUT(armed),
    .IRQ_OUT(irq));
  cft_src cft_src_i (.level_in(level), .phase_in(phase), .il1_out(il1), .il2_out(il2), .il3_out(il3));

  // Compare and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One Avalon cycle, read data left in q; a hang is left to the watchdog
  task automatic bus(input logic we, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= we;
    rd <= !we;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
    end while (wait_req !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask

  task automatic wrchk(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [31:0] e);
    bus(1'b1, a, d);
    rdchk(a, e);
  endtask

  task automatic tk(input int n);
    repeat (n * TICK) @(posedge clk);
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end

  // Count trip event pulses, one per trip entry
  always @(posedge clk) begin
    if (trip_evt === 1'b1)
      n_evt++;
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, OFS_START, 32'(rows[i].st));
      bus(1'b1, OFS_DEAD, 32'(rows[i].dd));
      bus(1'b1, OFS_WIN, 32'(rows[i].wn));
      phase <= 2'(i % 3);
      level <= '0;
      tk(rows[i].op);
      chk(32'(armed), 32'(rows[i].ar));
      level <= 16'h0032;
      tk(rows[i].pr);
      level <= CUR_W'(rows[i].fl);
      repeat (4) @(posedge clk);
      chk(32'(trip), 32'(rows[i].tr));
      tk(2);
      chk(32'(trip), 32'(rows[i].tr));
      level <= 16'h0032;
      repeat (4) @(posedge clk);
      chk(32'(trip), 32'h0000_0000);
    end
    // Second reset, then reset values and an unmapped place
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(OFS_CTRL, 32'(RST_ENABLE));
    rdchk(OFS_START, 32'(RST_START));
    rdchk(OFS_DEAD, 32'(RST_DEAD));
    rdchk(OFS_WIN, 32'(RST_WIN));
    rdchk(OFS_IRQ_MASK, 32'h0000_0000);
    rdchk(6'h3C, 32'h0000_0000);
    level <= 16'h0190;
    tk(2);
    chk(32'(trip), 32'h0000_0000);
    level <= 16'h0032;
    // Setting ranges are clamped
    wrchk(OFS_START, 32'h0000_01F4, 32'(START_MAX));
    wrchk(OFS_START, 32'h0000_0000, 32'(START_MIN));
    wrchk(OFS_WIN, 32'h0000_0000, 32'(WIN_MIN));
    wrchk(OFS_DEAD, 32'h0000_1FFF, 32'(DEAD_MAX));
    wrchk(OFS_DEAD, 32'h0000_0002, 32'h0000_0002);
    // Open pin ignored with select zero, used once selected
    dig <= 8'h01;
    tk(5);
    chk(32'(armed), 32'h0000_0000);
    bus(1'b1, OFS_CTRL, 32'h0000_0101);
    bus(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
    tk(5);
    chk(32'(armed), 32'h0000_0001);
    dig <= 8'h00;
    tk(1);
    level <= 16'h0190;
    repeat (6) @(posedge clk);
    chk(32'(trip), 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001);
    level <= 16'h0032;
    bus(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
    chk(q & 32'h0000_0001, 32'h0000_0001);
    bus(1'b1, OFS_IRQ_STAT, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0000_0000);
    level <= 16'h0190;
    tk(2);
    chk(32'(trip), 32'h0000_0000);
    // Dead-line count restarts when open drops
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
    bus(1'b1, OFS_DEAD, 32'h0000_0005);
    level <= '0;
    tk(3);
    level <= 16'h0032;
    @(posedge clk);
    level <= '0;
    tk(3);
    chk(32'(armed), 32'h0000_0000);
    tk(3);
    chk(32'(armed), 32'h0000_0001);
    // Virtual open input holds open, its release marks closure
    bus(1'b1, OFS_VIRT, 32'h0000_0001);
    bus(1'b1, OFS_CTRL, 32'h0000_0901);
    rdchk(OFS_IMAX, 32'h0000_0000);
    rdchk(OFS_STATUS, 32'h0000_0602);
    level <= 16'h0032;
    tk(2);
    chk(32'(armed), 32'h0000_0001);
    bus(1'b1, OFS_VIRT, 32'h0000_0000);
    level <= 16'h0190;
    repeat (6) @(posedge clk);
    chk(32'(trip), 32'h0000_0001);
    level <= 16'h0032;
    chk(32'(n_evt), 32'h0000_0004);
    tally_and_finish();
  end
endmodule // cft_closure_trip_test

// ### cft_pkg.sv
// Shared constants, register map and state encoding for the closure fault trip stage
package cft_pkg;

  // Data and field widths
  localparam int unsigned CUR_W    = 16;   // Current magnitude, units of 0.01 x In
  localparam int unsigned TMR_W    = 13;   // Timer setting, units of 10 ms ticks
  localparam int unsigned SEL_W    = 5;    // Open detection input select
  localparam int unsigned ADDR_W   = 6;    // Avalon byte address
  localparam int unsigned NUM_DIG_DEF  = 8;
  localparam int unsigned NUM_VIRT     = 8;

  // Clock and tick timing
  localparam longint unsigned CLK_HZ        = 100_000_000;
  localparam longint unsigned TICK_PERIOD_MS = 10;
  localparam int unsigned TICK_CYCLES_DEF   = int'(CLK_HZ / 1000 * TICK_PERIOD_MS);

  // Fixed low limit and setting ranges
  localparam logic [CUR_W-1:0] LOW_LIMIT    = 16'h0002;  // 0.02 x In
  localparam logic [CUR_W-1:0] START_MIN    = 16'h0064;  // 1.00 x In
  localparam logic [CUR_W-1:0] START_MAX    = 16'h012C;  // 3.00 x In
  localparam logic [TMR_W-1:0] DEAD_MIN     = 13'h0000;  // 0.00 s
  localparam logic [TMR_W-1:0] DEAD_MAX     = 13'h1770;  // 60.00 s
  localparam logic [TMR_W-1:0] WIN_MIN      = 13'h000A;  // 0.10 s
  localparam logic [TMR_W-1:0] WIN_MAX      = 13'h1770;  // 60.00 s

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_START    = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_DEAD     = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_WIN      = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_VIRT     = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_IMAX     = 6'h20;

  // Field positions
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_SEL_LSB  = 8;
  localparam int unsigned STAT_TRIP_BIT = 8;
  localparam int unsigned STAT_OPEN_BIT = 9;
  localparam int unsigned STAT_SEL_BIT  = 10;
  localparam int unsigned IRQ_TRIP_BIT  = 0;
  localparam int unsigned IRQ_ARM_BIT   = 1;
  localparam int unsigned IRQ_EXP_BIT   = 2;
  localparam int unsigned IRQ_W         = 3;

  // Reset values
  localparam logic              RST_ENABLE = 1'b1;
  localparam logic [SEL_W-1:0]  RST_SEL    = 5'h00;
  localparam logic [CUR_W-1:0]  RST_START  = 16'h0064;
  localparam logic [TMR_W-1:0]  RST_DEAD   = 13'h0064;
  localparam logic [TMR_W-1:0]  RST_WIN    = 13'h0064;

  // Stage states, one-hot
  typedef enum logic [4:0] {
    ST_WAIT_OPEN = 5'b00001,
    ST_ARMED     = 5'b00010,
    ST_CLOSED    = 5'b00100,
    ST_TRIP      = 5'b01000,
    ST_LOCK      = 5'b10000
  } cft_state_t;

endpackage

// ### cft_props.sv
// Port checker for the closure fault trip stage
`timescale 1ns/10ps
module cft_props #(
  parameter int unsigned NUM_DIG = cft_pkg::NUM_DIG_DEF
) (
  // Clock and reset
  input wire logic                      MCLK_IN,
  input wire logic                      RESET_N_IN,
  // Bus handshake
  input wire logic                      AVS_READ_IN,
  input wire logic                      AVS_WRITE_IN,
  input wire logic                      AVS_WAITREQUEST_OUT,
  // Stage inputs
  input wire logic [cft_pkg::CUR_W-1:0] IL1_IN,
  input wire logic [cft_pkg::CUR_W-1:0] IL2_IN,
  input wire logic [cft_pkg::CUR_W-1:0] IL3_IN,
  input wire logic [NUM_DIG-1:0]        DIGITAL_OPEN_INPUTS_IN,
  // Stage outputs
  input wire logic                      TRIP_OUT,
  input wire logic                      TRIP_EVENT_OUT,
  input wire logic                      ARMED_OUT
);
  import cft_pkg::*;
  logic [CUR_W-1:0] cur_max;
  logic             open_seen_r;
  logic             trip_d_r;

  // Largest phase current
  always_comb begin
    cur_max = (IL1_IN > IL2_IN) ? IL1_IN : IL2_IN;
    if (IL3_IN > cur_max)
      cur_max = IL3_IN;
  end

  // Open period seen since the last trip ended
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      open_seen_r <= 1'b0;
      trip_d_r    <= 1'b0;
    end else begin
      trip_d_r <= TRIP_OUT;
      if ((cur_max < LOW_LIMIT) || (|DIGITAL_OPEN_INPUTS_IN))
        open_seen_r <= 1'b1;
      else if (trip_d_r && !TRIP_OUT)
        open_seen_r <= 1'b0;
    end
  end

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  AST_EVT_WITH_RISE: assert property (TRIP_EVENT_OUT |-> TRIP_OUT && !$past(TRIP_OUT))
    else $error("trip event without trip rising");
  AST_EVT_ONCE: assert property ($rose(TRIP_OUT) |-> TRIP_EVENT_OUT ##1 !TRIP_EVENT_OUT)
    else $error("trip event not a single pulse");
  AST_TRIP_AFTER_OPEN: assert property ($rose(TRIP_OUT) |-> open_seen_r)
    else $error("trip without preceding open period");
  AST_ARM_AFTER_OPEN: assert property ($rose(ARMED_OUT) |-> open_seen_r)
    else $error("armed without preceding open period");
  AST_FAST_TRIP: assert property (ARMED_OUT && cur_max > START_MAX |-> ##[1:3] TRIP_OUT)
    else $error("trip late after overcurrent");
  AST_TRIP_STAYS: assert property (TRIP_OUT && cur_max > START_MAX |=> TRIP_OUT)
    else $error("trip dropped while current high");
  AST_TRIP_DROP: assert property (TRIP_OUT && cur_max <= START_MIN |-> ##[0:2] !TRIP_OUT)
    else $error("trip held after current fell");
  AST_WAIT_ANSWER: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
    else $error("bus request not answered");
  AST_WAIT_ONE: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
    else $error("waitrequest low too long");

  // Main scenarios
  COV_TRIP: cover property ($rose(TRIP_OUT));
  COV_EXPIRE: cover property ($fell(ARMED_OUT) && !TRIP_OUT);
  COV_WRITE: cover property (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT);
endmodule // cft_props

bind cft_closure_trip cft_props #(.NUM_DIG(NUM_DIG)) cft_props_i (
  .MCLK_IN(MCLK_IN), .RESET_N_IN(RESET_N_IN), .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
  .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .IL1_IN(IL1_IN), .IL2_IN(IL2_IN), .IL3_IN(IL3_IN),
  .DIGITAL_OPEN_INPUTS_IN(DIGITAL_OPEN_INPUTS_IN), .TRIP_OUT(TRIP_OUT), .TRIP_EVENT_OUT(TRIP_EVENT_OUT),
  .ARMED_OUT(ARMED_OUT));

// ### cft_src.sv
// Phase current source model feeding the stage
`timescale 1ns/10ps
module cft_src (
  // Commanded level and leading phase
  input  wire logic [cft_pkg::CUR_W-1:0] level_in,
  input  wire logic [1:0]                phase_in,
  // Phase currents
  output logic      [cft_pkg::CUR_W-1:0] il1_out,
  output logic      [cft_pkg::CUR_W-1:0] il2_out,
  output logic      [cft_pkg::CUR_W-1:0] il3_out
);
  import cft_pkg::*;
  assign il1_out = (phase_in == 2'h0) ? level_in : (level_in >> 1);
  assign il2_out = (phase_in == 2'h1) ? level_in : (level_in >> 1);
  assign il3_out = (phase_in == 2'h2) ? level_in : (level_in >> 1);
endmodule // cft_src

// ### cft_timer.sv
// Tick timer: counts ticks while running, clears when stopped
`timescale 1ns/10ps
module cft_timer (
  // Clock and reset
  input  wire logic MCLK_IN,
  input  wire logic RESET_N_IN,
  // Controller side
  cft_tmr_if.tmr    tmr_if
);
  import cft_pkg::*;

  logic [TMR_W-1:0] cnt_r;

  // Count ticks up to the limit, restart when run drops
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      cnt_r <= '0;
    end else if (!tmr_if.run) begin
      cnt_r <= '0;
    end else if (tmr_if.tick && (cnt_r < tmr_if.limit)) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Elapsed once the count reaches the limit
  assign tmr_if.done = tmr_if.run && (cnt_r >= tmr_if.limit);

endmodule // cft_timer

// ### cft_tmr_if.sv
// Interface between the stage controller and one tick timer
`timescale 1ns/10ps
interface cft_tmr_if;
  import cft_pkg::*;
  logic             tick;
  logic             run;
  logic [TMR_W-1:0] limit;
  logic             done;

  modport tmr (input tick, input run, input limit, output done);
  modport ctl (output tick, output run, output limit, input done);
endinterface
